// >>> design/pixel_palette_pkg.sv
// Purpose: types shared by the palette block
// Assumes: nothing beyond SystemVerilog
// Notes: constants live in pixel_palette_regs.svh
package pixel_palette_pkg;
    // Colour depth field, format register bits 1:0
    typedef enum logic [1:0] {
        DEPTH_4 = 2'h0,
        DEPTH_8 = 2'h1,
        DEPTH_15 = 2'h2,
        DEPTH_16 = 2'h3
    } depth_t;
    // Internal component bank selector
    typedef enum logic [2:0] {
        BANK_RED = 3'h1,
        BANK_GREEN = 3'h2,
        BANK_BLUE = 3'h4
    } bank_t;
endpackage

// >>> design/pixel_palette_regs.svh
// Purpose: offsets, field positions, reset values of the palette block
// Assumes: register index times four is the AXI byte address
// Notes: indices keep the printed offsets; byte address is index * 4
`ifndef PIXEL_PALETTE_REGS_SVH
`define PIXEL_PALETTE_REGS_SVH

`define PAL_MODE_IDX 10'h1E0
`define PAL_INDEX_IDX 10'h1E2
`define PAL_DATA_IDX 10'h1E4
`define PAL_FORMAT_IDX 10'h1E8
`define PAL_MODE_ADDR 12'h780
`define PAL_INDEX_ADDR 12'h788
`define PAL_DATA_ADDR 12'h790
`define PAL_FORMAT_ADDR 12'h7A0
`define PAL_MODE_RST 2'h0
`define PAL_INDEX_RST 8'h00
`define PAL_FORMAT_RST 6'h00
`define FMT_COLOR_BIT 2
`define FMT_DITHER_BIT 3
`define FMT_PASSIVE_BIT 4
`define FMT_BIG_BUF_BIT 5
`define BUF_TOP_SMALL 21'h07FFFF
`define BUF_TOP_BIG 21'h1FFFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> design/pixel_unpack_palette.sv
// Purpose: pixel unpacking, dual palette lookup, AXI4-Lite table access
// Assumes: fetch words arrive synchronous to aclk; one access of each kind
// Notes: colour outputs are 6 bits, left aligned; 5-bit sources pad LSB 0
`timescale 1ns/1ps
`include "pixel_palette_regs.svh"

module pixel_unpack_palette (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [15:0] fetch_data,
    input wire logic fetch_valid,
    output logic fetch_ready,
    output logic [20:0] buffer_top,
    output logic panel_valid,
    output logic [5:0] panel_red,
    output logic [5:0] panel_green,
    output logic [5:0] panel_blue,
    output logic crt_valid,
    output logic [5:0] crt_red,
    output logic [5:0] crt_green,
    output logic [5:0] crt_blue
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Step the bank selector red, green, blue, red
    function automatic pixel_palette_pkg::bank_t bank_step(
        input pixel_palette_pkg::bank_t b);
        unique case (b)
            pixel_palette_pkg::BANK_RED: bank_step = pixel_palette_pkg::BANK_GREEN;
            pixel_palette_pkg::BANK_GREEN: bank_step = pixel_palette_pkg::BANK_BLUE;
            default: bank_step = pixel_palette_pkg::BANK_RED;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [9:0] idx);
        is_mapped = idx == `PAL_MODE_IDX || idx == `PAL_INDEX_IDX ||
            idx == `PAL_DATA_IDX || idx == `PAL_FORMAT_IDX;
    endfunction

    // Keep only the four MSBs of a left-aligned component
    function automatic logic [5:0] trim4(input logic [5:0] v,
        input logic en);
        trim4 = en ? (v & 6'h3C) : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [1:0] mode_reg;
    logic [7:0] index_reg;
    logic [5:0] format_reg;
    pixel_palette_pkg::bank_t bank_reg;
    logic [3:0] pan_r [0:255];
    logic [3:0] pan_g [0:255];
    logic [3:0] pan_b [0:255];
    logic [3:0] crt_r [0:255];
    logic [3:0] crt_g [0:255];
    logic [3:0] crt_b [0:255];
    logic aw_held_reg, w_held_reg, ar_held_reg;
    logic [9:0] waddr_reg, raddr_reg;
    logic [7:0] wbyte_reg;
    logic wlane_reg;
    logic awready_reg, wready_reg, arready_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic wr_go, rd_go, aw_take, w_take, ar_take;
    logic aw_held_next, w_held_next, ar_held_next;
    logic data_wr, data_rd, to_crt_rd;
    logic [3:0] rd_comp;
    pixel_palette_pkg::depth_t depth;
    logic mono, trim;

    assign depth = pixel_palette_pkg::depth_t'(format_reg[1:0]);
    assign mono = !format_reg[`FMT_COLOR_BIT];
    assign trim = format_reg[`FMT_PASSIVE_BIT] && !format_reg[`FMT_DITHER_BIT];

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes; a read waits a cycle if a write goes first
    assign aw_take = awvalid && awready_reg;
    assign w_take = wvalid && wready_reg;
    assign ar_take = arvalid && arready_reg;
    assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
    assign rd_go = ar_held_reg && !rvalid_reg && !wr_go;
    assign aw_held_next = (aw_held_reg && !wr_go) || aw_take;
    assign w_held_next = (w_held_reg && !wr_go) || w_take;
    assign ar_held_next = (ar_held_reg && !rd_go) || ar_take;
    assign data_wr = wr_go && wlane_reg && waddr_reg == `PAL_DATA_IDX;
    assign data_rd = rd_go && raddr_reg == `PAL_DATA_IDX;
    assign to_crt_rd = mode_reg[1];

    // Channel holding registers and ready flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            ar_held_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            arready_reg <= 1'b0;
            waddr_reg <= 10'h000;
            raddr_reg <= 10'h000;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            ar_held_reg <= ar_held_next;
            awready_reg <= !aw_held_next;
            wready_reg <= !w_held_next;
            arready_reg <= !ar_held_next;
            if (aw_take) begin
                waddr_reg <= awaddr[11:2];
            end
            if (w_take) begin
                wbyte_reg <= wdata[7:0];
                wlane_reg <= wstrb[0];
            end
            if (ar_take) begin
                raddr_reg <= araddr[11:2];
            end
        end
    end

    // Write response; unmapped words answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= is_mapped(waddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Component picked by the bank selector for a host read
    always_comb begin
        unique case (bank_reg)
            pixel_palette_pkg::BANK_RED:
                rd_comp = to_crt_rd ? crt_r[index_reg] : pan_r[index_reg];
            pixel_palette_pkg::BANK_GREEN:
                rd_comp = to_crt_rd ? crt_g[index_reg] : pan_g[index_reg];
            default:
                rd_comp = to_crt_rd ? crt_b[index_reg] : pan_b[index_reg];
        endcase
    end

    // Read data; unused bits return zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end else if (rd_go) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= is_mapped(raddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (raddr_reg)
                `PAL_MODE_IDX: rdata_reg <= {30'h0, mode_reg};
                `PAL_INDEX_IDX: rdata_reg <= {24'h0, index_reg};
                `PAL_DATA_IDX: rdata_reg <= {24'h0, rd_comp, 4'h0};
                `PAL_FORMAT_IDX: rdata_reg <= {26'h0, format_reg};
                default: rdata_reg <= 32'h00000000;
            endcase
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers, address and bank stepping
    // A write lacking lane 0 leaves everything, bank included, untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= `PAL_MODE_RST;
            index_reg <= `PAL_INDEX_RST;
            format_reg <= `PAL_FORMAT_RST;
            bank_reg <= pixel_palette_pkg::BANK_RED;
        end else if (wr_go && wlane_reg) begin
            unique case (waddr_reg)
                `PAL_MODE_IDX: mode_reg <= wbyte_reg[1:0];
                `PAL_INDEX_IDX: begin
                    index_reg <= wbyte_reg;
                    bank_reg <= pixel_palette_pkg::BANK_RED;
                end
                `PAL_FORMAT_IDX: format_reg <= wbyte_reg[5:0];
                default: begin
                end
            endcase
            if (data_wr) begin
                bank_reg <= bank_step(bank_reg);
                if (bank_reg == pixel_palette_pkg::BANK_BLUE) begin
                    index_reg <= index_reg + 8'h01;
                end
            end
        end else if (data_rd) begin
            bank_reg <= bank_step(bank_reg);
            if (bank_reg == pixel_palette_pkg::BANK_BLUE) begin
                index_reg <= index_reg + 8'h01;
            end
        end
    end

    // Table writes; mode 00 and 11 write both tables, 01 panel, 10 CRT
    always_ff @(posedge aclk) begin
        if (data_wr && mode_reg != 2'h2) begin
            unique case (bank_reg)
                pixel_palette_pkg::BANK_RED: pan_r[index_reg] <= wbyte_reg[7:4];
                pixel_palette_pkg::BANK_GREEN: pan_g[index_reg] <= wbyte_reg[7:4];
                default: pan_b[index_reg] <= wbyte_reg[7:4];
            endcase
        end
        if (data_wr && mode_reg != 2'h1) begin
            unique case (bank_reg)
                pixel_palette_pkg::BANK_RED: crt_r[index_reg] <= wbyte_reg[7:4];
                pixel_palette_pkg::BANK_GREEN: crt_g[index_reg] <= wbyte_reg[7:4];
                default: crt_b[index_reg] <= wbyte_reg[7:4];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unpack stage: one pixel per cycle; a 4 bpp byte takes two cycles
    logic va_reg, pend_reg, fetch_ready_reg, fetch_take;
    logic [3:0] low_nib_reg;
    logic [7:0] pix_idx_reg;
    logic [15:0] word_reg;
    logic [20:0] buffer_top_reg;

    assign fetch_take = fetch_valid && fetch_ready_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            va_reg <= 1'b0;
            pend_reg <= 1'b0;
            fetch_ready_reg <= 1'b0;
            low_nib_reg <= 4'h0;
            pix_idx_reg <= 8'h00;
            word_reg <= 16'h0000;
        end else begin
            va_reg <= pend_reg || fetch_take;
            pend_reg <= fetch_take && depth == pixel_palette_pkg::DEPTH_4;
            fetch_ready_reg <=
                !(fetch_take && depth == pixel_palette_pkg::DEPTH_4);
            if (pend_reg) begin
                pix_idx_reg <= {4'h0, low_nib_reg};
            end else if (fetch_take) begin
                word_reg <= fetch_data;
                low_nib_reg <= fetch_data[3:0];
                unique case (depth)
                    pixel_palette_pkg::DEPTH_4:
                        pix_idx_reg <= {4'h0, fetch_data[7:4]};
                    pixel_palette_pkg::DEPTH_8:
                        pix_idx_reg <= fetch_data[7:0];
                    default: pix_idx_reg <= 8'h00;
                endcase
            end
        end
    end

    // Buffer size strap held by software; top byte address for fetch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buffer_top_reg <= `BUF_TOP_SMALL;
        end else begin
            buffer_top_reg <= format_reg[`FMT_BIG_BUF_BIT] ?
                `BUF_TOP_BIG : `BUF_TOP_SMALL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Colour stage: table lookup or direct decode, one cycle after unpack
    logic [5:0] wr6, wg6, wb6, pr6, pg6, pb6, cr6, cg6, cb6;
    logic wide;

    assign wide = depth[1];
    always_comb begin
        if (depth == pixel_palette_pkg::DEPTH_16) begin
            wr6 = {word_reg[15:11], 1'b0};
            wg6 = word_reg[10:5];
            wb6 = {word_reg[4:0], 1'b0};
        end else begin
            wr6 = {word_reg[14:10], 1'b0};
            wg6 = {word_reg[9:5], 1'b0};
            wb6 = {word_reg[4:0], 1'b0};
        end
        cr6 = wide ? wr6 : {crt_r[pix_idx_reg], 2'h0};
        cg6 = wide ? wg6 : {crt_g[pix_idx_reg], 2'h0};
        cb6 = wide ? wb6 : {crt_b[pix_idx_reg], 2'h0};
        pr6 = wide ? trim4(wr6, trim) : {pan_r[pix_idx_reg], 2'h0};
        pg6 = wide ? trim4(wg6, trim) : {pan_g[pix_idx_reg], 2'h0};
        pb6 = wide ? trim4(wb6, trim) : {pan_b[pix_idx_reg], 2'h0};
        if (mono) begin
            pr6 = pg6;
            pb6 = pg6;
        end
    end

    // Output flops toward the modulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            panel_valid <= 1'b0;
            crt_valid <= 1'b0;
            panel_red <= 6'h00;
            panel_green <= 6'h00;
            panel_blue <= 6'h00;
            crt_red <= 6'h00;
            crt_green <= 6'h00;
            crt_blue <= 6'h00;
        end else begin
            panel_valid <= va_reg;
            crt_valid <= va_reg;
            panel_red <= pr6;
            panel_green <= pg6;
            panel_blue <= pb6;
            crt_red <= cr6;
            crt_green <= cg6;
            crt_blue <= cb6;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign arready = arready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign fetch_ready = fetch_ready_reg;
    assign buffer_top = buffer_top_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_index_bank_red;
        wr_go && wlane_reg && waddr_reg == `PAL_INDEX_IDX
            |=> bank_reg == pixel_palette_pkg::BANK_RED;
    endproperty
    a_index_bank_red: assert property (p_index_bank_red)
        else $error("bank not red after address write");

    property p_three_step;
        (data_wr || data_rd) && bank_reg == pixel_palette_pkg::BANK_RED
            |=> bank_reg == pixel_palette_pkg::BANK_GREEN;
    endproperty
    a_three_step: assert property (p_three_step)
        else $error("bank did not step to green");

    property p_addr_inc;
        (data_wr || data_rd) && bank_reg == pixel_palette_pkg::BANK_BLUE
            |=> index_reg == $past(index_reg) + 8'h01 &&
                bank_reg == pixel_palette_pkg::BANK_RED;
    endproperty
    a_addr_inc: assert property (p_addr_inc)
        else $error("address not incremented after blue");

    property p_wrap;
        data_rd && bank_reg == pixel_palette_pkg::BANK_BLUE &&
            index_reg == 8'hFF |=> index_reg == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("address did not wrap");

    property p_nibble_pair;
        fetch_take && depth == pixel_palette_pkg::DEPTH_4
            |=> !fetch_ready ##1 fetch_ready && panel_valid ##1 panel_valid;
    endproperty
    a_nibble_pair: assert property (p_nibble_pair)
        else $error("4 bpp byte not split into two pixels");

    property p_small_index;
        va_reg && depth == pixel_palette_pkg::DEPTH_4 |-> pix_idx_reg[7:4] == 4'h0;
    endproperty
    a_small_index: assert property (p_small_index)
        else $error("4 bpp index above 15");

    property p_d15_crt;
        va_reg && depth == pixel_palette_pkg::DEPTH_15
            |=> crt_red == {$past(word_reg[14:10]), 1'b0} &&
                crt_blue == {$past(word_reg[4:0]), 1'b0};
    endproperty
    a_d15_crt: assert property (p_d15_crt)
        else $error("15 bpp decode wrong");

    property p_d16_green;
        va_reg && depth == pixel_palette_pkg::DEPTH_16
            |=> crt_green == $past(word_reg[10:5]);
    endproperty
    a_d16_green: assert property (p_d16_green)
        else $error("16 bpp green decode wrong");

    property p_trim;
        va_reg && wide && trim |=> panel_green[1:0] == 2'h0 &&
            panel_red[1:0] == 2'h0;
    endproperty
    a_trim: assert property (p_trim)
        else $error("passive undithered output not trimmed");

    property p_mono_gray;
        va_reg && mono |=> panel_red == panel_green &&
            panel_blue == panel_green;
    endproperty
    a_mono_gray: assert property (p_mono_gray)
        else $error("mono panel not driven by green only");

    // Register-specific unused bits, not just the upper word
    property p_rdata_zero;
        rd_go |=> rdata[31:8] == 24'h0 &&
            ($past(raddr_reg) != `PAL_DATA_IDX || rdata[3:0] == 4'h0) &&
            ($past(raddr_reg) != `PAL_MODE_IDX || rdata[7:2] == 6'h0);
    endproperty
    a_rdata_zero: assert property (p_rdata_zero)
        else $error("unused read bits not zero");

    c_nibble: cover property (fetch_take &&
        depth == pixel_palette_pkg::DEPTH_4 ##2 panel_valid);
    c_wrap: cover property (data_wr && index_reg == 8'hFF &&
        bank_reg == pixel_palette_pkg::BANK_BLUE);
    c_mono16: cover property (va_reg && mono &&
        depth == pixel_palette_pkg::DEPTH_16);
    c_both_wait: cover property (wr_go && ar_held_reg && !rvalid_reg);

endmodule

// >>> tb/pixel_source.sv
// Purpose: display buffer side, feeds pixel words to the block
// Assumes: the bench queues words with put
// Notes: idle data toggles so a stale word never looks valid
`timescale 1ns/1ps
module pixel_source (
    input wire logic aclk,
    input wire logic fetch_ready,
    output logic [15:0] fetch_data,
    output logic fetch_valid
);
    logic [15:0] q[$];
    initial fetch_valid = 1'b0;
    initial fetch_data = 16'h0000;
    task automatic put(input logic [15:0] w);
        q.push_back(w);
    endtask
    // Hold word until taken; idle bus is scrambled, not held
    always @(posedge aclk) begin
        if (fetch_valid && fetch_ready)
            void'(q.pop_front());
        if (q.size() > 0) begin
            fetch_valid <= 1'b1;
            fetch_data <= q[0];
        end else begin
            fetch_valid <= 1'b0;
            fetch_data <= ~fetch_data;
        end
    end
endmodule

// >>> tb/tb_pixel_unpack_palette.sv
// Purpose: self-checking bench for pixel_unpack_palette
// Assumes: register addresses from pixel_palette_regs.svh
// Notes: a monitor queues every pixel; tests compare in order
`timescale 1ns/1ps
`include "pixel_palette_regs.svh"
module tb_pixel_unpack_palette;
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic [11:0] awaddr = 12'h000, araddr = 12'h000;
logic [31:0] wdata = 32'h0, rdata;
logic [3:0] wstrb = 4'hF;
logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
logic arvalid = 1'b0, rready = 1'b0;
logic awready, wready, bvalid, arready, rvalid;
logic [1:0] bresp, rresp;
logic [15:0] fetch_data;
logic fetch_valid, fetch_ready, panel_valid, crt_valid;
logic [20:0] buffer_top;
logic [5:0] panel_red, panel_green, panel_blue;
logic [5:0] crt_red, crt_green, crt_blue;
logic [37:0] pq[$];
int miscompares = 0;
int check_count = 0;
pixel_unpack_palette uut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .fetch_data, .fetch_valid, .fetch_ready, .buffer_top,
    .panel_valid, .panel_red, .panel_green, .panel_blue, .crt_valid,
    .crt_red, .crt_green, .crt_blue);
pixel_source src (.aclk, .fetch_ready, .fetch_data, .fetch_valid);
always #12.5 aclk = ~aclk;
// Capture each pixel; both valids are kept so a lone pulse shows up
always @(posedge aclk) begin
    if (panel_valid || crt_valid)
        pq.push_back({panel_valid, crt_valid, panel_red, panel_green,
            panel_blue, crt_red, crt_green, crt_blue});
end
////////////////////////////////////////////////////////////
task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
        miscompares++;
        $display("mismatch %0t got %h exp %h", $time, g, e);
    end
endtask
task automatic chk_px(input logic [35:0] e);
    logic [37:0] g;
    g = 'x;
    if (pq.size() > 0)
        g = pq.pop_front();
    check_count++;
    if (g !== {2'b11, e}) begin
        miscompares++;
        $display("mismatch %0t pixel %h exp %h", $time, g, {2'b11, e});
    end
endtask
function automatic logic [17:0] c4(input logic [3:0] r, g, b);
    return {r, 2'h0, g, 2'h0, b, 2'h0};
endfunction
// Extra edge at the end so no strobe is set twice in one step
task automatic wr(input logic [11:0] a, input logic [31:0] v,
    input logic [1:0] er = `RESP_OKAY);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) break;
    end
    bready <= 1'b0;
    chk32({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
endtask
task automatic rdc(input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) break;
    end
    rready <= 1'b0;
    chk32(rdata, e);
    chk32({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
endtask
task automatic feed(input logic [5:0] f, input logic [15:0] w);
    wr(`PAL_FORMAT_ADDR, {26'h0, f});
    src.put(w);
    repeat (8) @(posedge aclk);
endtask
////////////////////////////////////////////////////////////
task automatic t_regs;
    chk32({11'h0, buffer_top}, {11'h0, `BUF_TOP_SMALL});
    rdc(`PAL_MODE_ADDR, 32'h0, `RESP_OKAY);
    rdc(`PAL_INDEX_ADDR, 32'h0, `RESP_OKAY);
    rdc(12'h7FC, 32'h0, `RESP_SLVERR);
    wr(12'h7FC, 32'h0, `RESP_SLVERR);
    wr(`PAL_FORMAT_ADDR, 32'h20);
    repeat (2) @(posedge aclk);
    chk32({11'h0, buffer_top}, {11'h0, `BUF_TOP_BIG});
    wr(`PAL_FORMAT_ADDR, 32'h0);
    repeat (2) @(posedge aclk);
    chk32({11'h0, buffer_top}, {11'h0, `BUF_TOP_SMALL});
    wr(`PAL_MODE_ADDR, 32'hFF);
    rdc(`PAL_MODE_ADDR, 32'h3, `RESP_OKAY);
    $display("test regs done");
endtask
task automatic t_table;
    wr(`PAL_MODE_ADDR, 32'h0);
    wr(`PAL_INDEX_ADDR, 32'hFF);
    for (int k = 0; k < 9; k++)
        wr(`PAL_DATA_ADDR, {24'h0, 4'(k + 3), 4'hF});
    rdc(`PAL_INDEX_ADDR, 32'h02, `RESP_OKAY);
    wr(`PAL_INDEX_ADDR, 32'hFF);
    for (int k = 0; k < 3; k++)
        rdc(`PAL_DATA_ADDR, {24'h0, 4'(k + 3), 4'h0}, `RESP_OKAY);
    rdc(`PAL_INDEX_ADDR, 32'h0, `RESP_OKAY);
    rdc(`PAL_DATA_ADDR, 32'h60, `RESP_OKAY);
    wr(`PAL_INDEX_ADDR, 32'h0);
    rdc(`PAL_DATA_ADDR, 32'h60, `RESP_OKAY);
    // Panel-only write must leave the other table alone
    wr(`PAL_MODE_ADDR, 32'h1);
    wr(`PAL_INDEX_ADDR, 32'h0);
    for (int k = 0; k < 3; k++)
        wr(`PAL_DATA_ADDR, {24'h0, 4'(k + 12), 4'h0});
    wr(`PAL_MODE_ADDR, 32'h2);
    wr(`PAL_INDEX_ADDR, 32'h0);
    rdc(`PAL_DATA_ADDR, 32'h60, `RESP_OKAY);
    wr(`PAL_MODE_ADDR, 32'h3);
    wr(`PAL_INDEX_ADDR, 32'h0);
    rdc(`PAL_DATA_ADDR, 32'h60, `RESP_OKAY);
    wr(`PAL_MODE_ADDR, 32'h0);
    wr(`PAL_INDEX_ADDR, 32'h0);
    rdc(`PAL_DATA_ADDR, 32'hC0, `RESP_OKAY);
    $display("test table done");
endtask
task automatic t_lookup;
    feed(6'h05, 16'h00FF);
    chk_px({c4(4'h3, 4'h4, 4'h5), c4(4'h3, 4'h4, 4'h5)});
    feed(6'h04, 16'h0001);
    chk_px({c4(4'hC, 4'hD, 4'hE), c4(4'h6, 4'h7, 4'h8)});
    chk_px({c4(4'h9, 4'hA, 4'hB), c4(4'h9, 4'hA, 4'hB)});
    feed(6'h00, 16'h0001);
    chk_px({c4(4'hD, 4'hD, 4'hD), c4(4'h6, 4'h7, 4'h8)});
    chk_px({c4(4'hA, 4'hA, 4'hA), c4(4'h9, 4'hA, 4'hB)});
    $display("test lookup done");
endtask
task automatic t_direct;
    logic [17:0] f;
    f = {6'h2A, 6'h1E, 6'h1A};
    feed(6'h07, 16'hABCD);
    chk_px({f, f});
    feed(6'h1F, 16'hABCD);
    chk_px({f, f});
    feed(6'h17, 16'hABCD);
    chk_px({6'h28, 6'h1C, 6'h18, f});
    feed(6'h03, 16'hABCD);
    chk_px({{3{6'h1E}}, f});
    f = {6'h14, 6'h3C, 6'h1A};
    feed(6'h06, 16'hABCD);
    chk_px({f, f});
    feed(6'h06, 16'h2BCD);
    chk_px({f, f});
    feed(6'h02, 16'hABCD);
    chk_px({{3{6'h3C}}, f});
    feed(6'h12, 16'hABED);
    chk_px({{3{6'h3C}}, 6'h14, 6'h3E, 6'h1A});
    $display("test direct done");
endtask
task finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
// Sequence; reset held four cycles
initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_table;
    t_lookup;
    t_direct;
    finish_test;
end
// Whole run needs well under 2000 cycles
initial begin
    #200us;
    miscompares++;
    finish_test;
end
endmodule
